//--- pie_enable_bank.sv
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pie_enable_bank
#(
    parameter bit HAS_COMP_TWO = 1'b1
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pie_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [pie_pkg::DAT_W-1:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [pie_pkg::DAT_W-1:0] wb_dat_o,
    // second bank events
    input wire logic osc_fail_evt,
    input wire logic comparator_two_evt,
    input wire logic comparator_one_evt,
    input wire logic eeprom_write_done_evt,
    input wire logic serial_bus_collision_evt,
    input wire logic capcmp_two_evt,
    // third bank events
    input wire logic capcmp_four_evt,
    input wire logic capcmp_three_evt,
    input wire logic timer_six_match_evt,
    input wire logic timer_four_match_evt,
    // request to the core
    output logic periph_irq
);
    import pie_pkg::*;

    // ----------------------------------------------------------------
    // masks that depend on the variant
    // ----------------------------------------------------------------
    localparam logic [7:0] TWO_MASK =
        HAS_COMP_TWO ? TWO_IMPL_MASK : (TWO_IMPL_MASK & ~COMP_TWO_MASK);

    logic wr_stb;
    logic [DAT_W-1:0] rd_value;
    logic [REG_W-1:0] wr_byte;
    logic [REG_W-1:0] evt_two;
    logic [REG_W-1:0] evt_three;
    logic [REG_W-1:0] flags_two;
    logic [REG_W-1:0] flags_three;
    logic wr_flag_two;
    logic wr_flag_three;

    // enable and control state
    logic [REG_W-1:0] en_two_r;
    logic [REG_W-1:0] en_two_nxt;
    logic [REG_W-1:0] en_three_r;
    logic [REG_W-1:0] en_three_nxt;
    logic [REG_W-1:0] gctl_r;
    logic [REG_W-1:0] gctl_nxt;
    logic irq_r;
    logic irq_nxt;
    logic group_open;
    logic [REG_W-1:0] pend_two;
    logic [REG_W-1:0] pend_three;
    logic src_req;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    pie_wb_slave u_wb
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .rd_value(rd_value),
        .wr_stb(wr_stb)
    );

    assign wr_byte = wb_dat_i[REG_W-1:0];
    assign wr_flag_two = wr_stb && (wb_adr_i == FLAG_TWO_OFS);
    assign wr_flag_three = wr_stb && (wb_adr_i == FLAG_THREE_OFS);

    // ----------------------------------------------------------------
    // event vectors
    // ----------------------------------------------------------------
    always_comb
    begin
        evt_two = REG_RESET;
        evt_two[OSC_FAIL_BIT] = osc_fail_evt;
        evt_two[COMP_TWO_BIT] = comparator_two_evt;
        evt_two[COMP_ONE_BIT] = comparator_one_evt;
        evt_two[EEPROM_DONE_BIT] = eeprom_write_done_evt;
        evt_two[BUS_COLL_BIT] = serial_bus_collision_evt;
        evt_two[CAPCMP_TWO_BIT] = capcmp_two_evt;
        evt_three = REG_RESET;
        evt_three[CAPCMP_FOUR_BIT] = capcmp_four_evt;
        evt_three[CAPCMP_THREE_BIT] = capcmp_three_evt;
        evt_three[TIMER_SIX_BIT] = timer_six_match_evt;
        evt_three[TIMER_FOUR_BIT] = timer_four_match_evt;
    end

    // ----------------------------------------------------------------
    // sticky flag banks, write one to clear
    // ----------------------------------------------------------------
    pie_flag_bank #(.WIDTH(REG_W), .IMPL_MASK(TWO_MASK)) u_flags_two
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .evt(evt_two),
        .clr_stb(wr_flag_two),
        .clr_data(wr_byte),
        .flags(flags_two)
    );

    pie_flag_bank #(.WIDTH(REG_W), .IMPL_MASK(THREE_IMPL_MASK)) u_flags_three
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .evt(evt_three),
        .clr_stb(wr_flag_three),
        .clr_data(wr_byte),
        .flags(flags_three)
    );

    // ----------------------------------------------------------------
    // enable and control registers
    // ----------------------------------------------------------------
    always_comb
    begin
        en_two_nxt = en_two_r;
        en_three_nxt = en_three_r;
        gctl_nxt = gctl_r;
        if (wr_stb)
        begin
            case (wb_adr_i)
                EN_TWO_OFS: en_two_nxt = wr_byte & TWO_MASK;
                EN_THREE_OFS: en_three_nxt = wr_byte & THREE_IMPL_MASK;
                GLOBAL_CTRL_OFS: gctl_nxt = wr_byte & GLOBAL_IMPL_MASK;
                default: ; // other offsets leave these alone
            endcase
        end
    end

    // all enables clear on reset
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_two_r <= REG_RESET;
            en_three_r <= REG_RESET;
            gctl_r <= REG_RESET;
        end
        else
        begin
            en_two_r <= en_two_nxt;
            en_three_r <= en_three_nxt;
            gctl_r <= gctl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read mux, unmapped offsets read zero
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_value = BUS_ZERO;
        case (wb_adr_i)
            EN_TWO_OFS: rd_value[REG_W-1:0] = en_two_r;
            EN_THREE_OFS: rd_value[REG_W-1:0] = en_three_r;
            FLAG_TWO_OFS: rd_value[REG_W-1:0] = flags_two;
            FLAG_THREE_OFS: rd_value[REG_W-1:0] = flags_three;
            GLOBAL_CTRL_OFS: rd_value[REG_W-1:0] = gctl_r;
            default: rd_value = BUS_ZERO;
        endcase
    end

    // ----------------------------------------------------------------
    // interrupt request to the core
    // ----------------------------------------------------------------
    assign group_open = gctl_r[PERIPH_GROUP_EN_BIT]
                     && gctl_r[GLOBAL_EN_BIT];

    // each source passes only while its own enable bit is set
    always_comb
    begin
        pend_two = flags_two & en_two_r;
        pend_three = flags_three & en_three_r;
        src_req = pend_two[OSC_FAIL_BIT]
            || pend_two[COMP_TWO_BIT]
            || pend_two[COMP_ONE_BIT]
            || pend_two[EEPROM_DONE_BIT]
            || pend_two[BUS_COLL_BIT]
            || pend_two[CAPCMP_TWO_BIT]
            || pend_three[CAPCMP_FOUR_BIT]
            || pend_three[CAPCMP_THREE_BIT]
            || pend_three[TIMER_SIX_BIT]
            || pend_three[TIMER_FOUR_BIT];
        // group and global enables gate the ORed sources
        irq_nxt = group_open && src_req;
    end

    // register the request
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_r <= 1'b0;
        else
            irq_r <= irq_nxt;
    end

    assign periph_irq = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    group_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !$past(gctl_r[PERIPH_GROUP_EN_BIT]) |-> !periph_irq)
        else $error("request raised with peripheral group closed");

    osc_fail_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (group_open && flags_two[OSC_FAIL_BIT] && en_two_r[OSC_FAIL_BIT])
        |=> periph_irq)
        else $error("enabled oscillator fail did not request");

    comp_two_absent_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !HAS_COMP_TWO |-> !en_two_r[COMP_TWO_BIT] && !flags_two[COMP_TWO_BIT])
        else $error("comparator two bit present on small variant");

    comp_one_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (group_open && flags_two[COMP_ONE_BIT] && en_two_r[COMP_ONE_BIT])
        |=> periph_irq)
        else $error("enabled comparator one did not request");

    eeprom_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (group_open && flags_two[EEPROM_DONE_BIT]
        && en_two_r[EEPROM_DONE_BIT]) |=> periph_irq)
        else $error("enabled eeprom write done did not request");

    bus_coll_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (group_open && flags_two[BUS_COLL_BIT]
        && en_two_r[BUS_COLL_BIT]) |=> periph_irq)
        else $error("enabled bus collision did not request");

    capcmp_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (group_open && ((flags_two[CAPCMP_TWO_BIT] && en_two_r[CAPCMP_TWO_BIT])
        || (flags_three[CAPCMP_THREE_BIT] && en_three_r[CAPCMP_THREE_BIT])))
        |=> periph_irq)
        else $error("enabled capture compare did not request");

    absent_bits_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (en_two_r & ~TWO_IMPL_MASK) == REG_RESET
        && (en_three_r & ~THREE_IMPL_MASK) == REG_RESET)
        else $error("unimplemented enable bit set");

    enable_write_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr_stb && wb_adr_i == EN_THREE_OFS)
        |=> en_three_r == ($past(wr_byte) & THREE_IMPL_MASK))
        else $error("third enable bank write not taken");

    timer_gate_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (group_open && |(flags_three & en_three_r)) |=> periph_irq)
        else $error("enabled third bank source did not request");

    flag_set_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        timer_four_match_evt |=> flags_three[TIMER_FOUR_BIT])
        else $error("event did not set its flag");

    set_beats_clear_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (osc_fail_evt && wr_flag_two) |=> flags_two[OSC_FAIL_BIT])
        else $error("clear beat a simultaneous event");

    irq_cause_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        periph_irq |-> $past(group_open)
        && $past(|(flags_two & en_two_r) || |(flags_three & en_three_r)))
        else $error("request without an enabled pending flag");

    ack_pulse_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule : pie_enable_bank
`default_nettype wire

//--- pie_pkg.sv
// shared constants for the peripheral interrupt enable bank
`default_nettype none
package pie_pkg;
    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 8;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] EN_TWO_OFS = 8'h00;
    localparam logic [7:0] EN_THREE_OFS = 8'h04;
    localparam logic [7:0] FLAG_TWO_OFS = 8'h08;
    localparam logic [7:0] FLAG_THREE_OFS = 8'h0C;
    localparam logic [7:0] GLOBAL_CTRL_OFS = 8'h10;
    // ----------------------------------------------------------------
    // bit positions, second bank
    // ----------------------------------------------------------------
    localparam int OSC_FAIL_BIT = 7;
    localparam int COMP_TWO_BIT = 6;
    localparam int COMP_ONE_BIT = 5;
    localparam int EEPROM_DONE_BIT = 4;
    localparam int BUS_COLL_BIT = 3;
    localparam int CAPCMP_TWO_BIT = 0;
    // ----------------------------------------------------------------
    // bit positions, third bank
    // ----------------------------------------------------------------
    localparam int CAPCMP_FOUR_BIT = 5;
    localparam int CAPCMP_THREE_BIT = 4;
    localparam int TIMER_SIX_BIT = 3;
    localparam int TIMER_FOUR_BIT = 1;
    // ----------------------------------------------------------------
    // global control bits
    // ----------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_GROUP_EN_BIT = 6;
    // ----------------------------------------------------------------
    // implemented-bit masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TWO_IMPL_MASK = 8'hF9;
    localparam logic [7:0] THREE_IMPL_MASK = 8'h3A;
    localparam logic [7:0] GLOBAL_IMPL_MASK = 8'hC0;
    localparam logic [7:0] COMP_TWO_MASK = 8'h40;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
endpackage : pie_pkg
`default_nettype wire

//--- pie_flag_bank.sv
// sticky interrupt flag bank, set by events, cleared by writing ones
`timescale 1ns/1ps
`default_nettype none
module pie_flag_bank
#(
    parameter int WIDTH = 8,
    parameter logic [7:0] IMPL_MASK = 8'hFF
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // events and software clear
    input wire logic [WIDTH-1:0] evt,
    input wire logic clr_stb,
    input wire logic [WIDTH-1:0] clr_data,
    // flag state
    output logic [WIDTH-1:0] flags
);
    import pie_pkg::*;

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (WIDTH != REG_W)
    begin : g_bad_width
        $error("flag bank width must match register width");
    end

    logic [WIDTH-1:0] flag_r;
    logic [WIDTH-1:0] flag_nxt;

    // ----------------------------------------------------------------
    // per-bit sticky flag, set wins over clear
    // ----------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_comb
        begin
            if (!IMPL_MASK[i])
                flag_nxt[i] = 1'b0; // absent bit stays zero
            else if (evt[i])
                flag_nxt[i] = 1'b1;
            else if (clr_stb && clr_data[i])
                flag_nxt[i] = 1'b0;
            else
                flag_nxt[i] = flag_r[i];
        end
    end

    // register the flags
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            flag_r <= REG_RESET;
        else
            flag_r <= flag_nxt;
    end

    assign flags = flag_r;
endmodule : pie_flag_bank
`default_nettype wire

//--- pie_wb_slave.sv
// classic wishbone slave handshake with registered read data
`timescale 1ns/1ps
`default_nettype none
module pie_wb_slave
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // wishbone request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    // wishbone answer
    output logic wb_ack_o,
    output logic [pie_pkg::DAT_W-1:0] wb_dat_o,
    // register file side
    input wire logic [pie_pkg::DAT_W-1:0] rd_value,
    output logic wr_stb
);
    import pie_pkg::*;

    logic ack_r;
    logic ack_nxt;
    logic [DAT_W-1:0] dat_r;
    logic [DAT_W-1:0] dat_nxt;

    // ack one cycle after the request, dropped the cycle after
    always_comb
    begin
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = ack_nxt ? rd_value : BUS_ZERO;
    end

    // register ack and read data
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_r <= 1'b0;
            dat_r <= BUS_ZERO;
        end
        else
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // write lands on the edge at which the master sees ack
    assign wr_stb = ack_r && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule : pie_wb_slave
`default_nettype wire

//--- pie_core_model.sv
// behavioural model of the core's interrupt entry logic
`timescale 1ns/1ps
`default_nettype none
module pie_core_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // request from the enable bank
    input wire logic periph_irq,
    // interrupt entries taken so far
    output var int entry_cnt
);
    logic irq_r;
    // one entry is taken on each rising edge of the level request
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_r <= 1'b0;
            entry_cnt <= 0;
        end
        else
        begin
            irq_r <= periph_irq;
            if (periph_irq && !irq_r)
                entry_cnt <= entry_cnt + 1;
        end
    end
endmodule : pie_core_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // stimulus, answers and model state
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [9:0] evt = 10'h000;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic irq_s;
    logic [31:0] rdat_s;
    int entries;
    int fails = 0;
    int num_checks = 0;
    int base;
    logic [7:0] en2 = 8'h00, en3 = 8'h00, fl2 = 8'h00, fl3 = 8'h00;
    logic [7:0] gc = 8'h00;
    logic [15:0] m;
    logic [31:0] rnd = 32'hD16E837B;
    logic [31:0] q;
    logic [31:0] qs;
    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // design and far-side model
    // ------------------------------------------------------------
    pie_enable_bank #(.HAS_COMP_TWO(1'b1)) uut (
        .core_clk(core_clk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .osc_fail_evt(evt[9]), .comparator_two_evt(evt[8]),
        .comparator_one_evt(evt[7]), .eeprom_write_done_evt(evt[6]),
        .serial_bus_collision_evt(evt[5]), .capcmp_two_evt(evt[4]),
        .capcmp_four_evt(evt[3]), .capcmp_three_evt(evt[2]),
        .timer_six_match_evt(evt[1]), .timer_four_match_evt(evt[0]),
        .periph_irq(irq));
    // small variant without the comparator two bit
    pie_enable_bank #(.HAS_COMP_TWO(1'b0)) uut_small (
        .core_clk(core_clk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(), .wb_dat_o(rdat_s),
        .osc_fail_evt(evt[9]), .comparator_two_evt(evt[8]),
        .comparator_one_evt(evt[7]), .eeprom_write_done_evt(evt[6]),
        .serial_bus_collision_evt(evt[5]), .capcmp_two_evt(evt[4]),
        .capcmp_four_evt(evt[3]), .capcmp_three_evt(evt[2]),
        .timer_six_match_evt(evt[1]), .timer_four_match_evt(evt[0]),
        .periph_irq(irq_s));
    pie_core_model core (.core_clk(core_clk), .reset_n(reset_n),
        .periph_irq(irq), .entry_cnt(entries));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // event vector to flag layout: {bank three, bank two}
    function automatic logic [15:0] emap(input logic [9:0] e);
        return {2'b00, e[3], e[2], e[1], 1'b0, e[0], 1'b0,
            e[9], e[8], e[7], e[6], e[5], 2'b00, e[4]};
    endfunction : emap
    // model register value at a byte offset
    function automatic logic [7:0] mreg(input logic [7:0] a);
        case (a)
            8'h00: return en2;
            8'h04: return en3;
            8'h08: return fl2;
            8'h0C: return fl3;
            8'h10: return gc;
            default: return 8'h00;
        endcase
    endfunction : mreg
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        @(posedge core_clk);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n == 50)
            fails++;
        r = rdat;
        qs = rdat_s;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        bus(1'b1, a, d, s, q);
        if (s[0])
        begin
            case (a)
                8'h00: en2 = d[7:0] & 8'hF9;
                8'h04: en3 = d[7:0] & 8'h3A;
                8'h08: fl2 = fl2 & ~d[7:0];
                8'h0C: fl3 = fl3 & ~d[7:0];
                8'h10: gc = d[7:0] & 8'hC0;
                default: ;
            endcase
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic [7:0] sm;
        bus(1'b0, a, 32'h0000_0000, 4'h0, q);
        chk(q, {24'h000000, mreg(a)});
        // the small variant has no comparator two bit
        sm = (a == 8'h00 || a == 8'h08) ? 8'hBF : 8'hFF;
        chk(qs, {24'h000000, mreg(a) & sm});
    endtask : rd
    // pulse events for one cycle, flags follow at the next edge
    task automatic ev(input logic [9:0] e);
        m = emap(e);
        @(posedge core_clk);
        evt <= e;
        @(posedge core_clk);
        evt <= 10'h000;
        fl2 = fl2 | m[7:0];
        fl3 = fl3 | m[15:8];
    endtask : ev
    // request is flag and enable, group and global, ored over sources
    task automatic ck_irq;
        logic e;
        logic es;
        e = gc[7] & gc[6] & (|((fl2 & en2) | (fl3 & en3)));
        es = gc[7] & gc[6] & (|((fl2 & en2 & 8'hBF) | (fl3 & en3)));
        repeat (2) @(posedge core_clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
        chk({31'h0, irq_s}, {31'h0, es});
    endtask : ck_irq
    task automatic rd_all;
        for (int a = 0; a <= 20; a += 4)
            rd(a[7:0]);
    endtask : rd_all
    task automatic stop_test;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        stop_test;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_all;
        $display("test reset values done");
        // all ones, then random patterns, then a write with sel[0] low
        wr(8'h00, 32'hFFFF_FFFF, 4'hF);
        wr(8'h04, 32'hFFFF_FFFF, 4'hF);
        rd(8'h00);
        rd(8'h04);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            wr(8'h00, rnd, 4'hF);
            wr(8'h04, rnd >> 8, 4'hF);
            rd(8'h00);
            rd(8'h04);
        end
        wr(8'h00, 32'h0000_0000, 4'hE);
        rd(8'h00);
        $display("test register access done");
        // flags set with every source enable off, group and global on
        wr(8'h00, 32'h0, 4'hF);
        wr(8'h04, 32'h0, 4'hF);
        wr(8'h10, 32'hC0, 4'hF);
        for (int i = 0; i < 10; i++)
        begin
            ev(10'h001 << i);
            rd(8'h08);
            rd(8'h0C);
            ck_irq;
        end
        // clear and event in one cycle: the flag stays set
        fork
            wr(8'h08, 32'hFF, 4'hF);
            begin
                repeat (2) @(posedge core_clk);
                evt <= 10'h200;
                @(posedge core_clk);
                evt <= 10'h000;
            end
        join
        fl2 = fl2 | 8'h80;
        rd(8'h08);
        $display("test flags done");
        // each source alone through group, global and its own enable
        base = entries;
        for (int i = 0; i < 10; i++)
        begin
            m = emap(10'h001 << i);
            wr(8'h08, 32'hFF, 4'hF);
            wr(8'h0C, 32'hFF, 4'hF);
            wr(8'h00, {24'h0, m[7:0]}, 4'hF);
            wr(8'h04, {24'h0, m[15:8]}, 4'hF);
            wr(8'h10, 32'h80, 4'hF);
            ev(10'h001 << i);
            ck_irq;
            wr(8'h10, 32'h40, 4'hF);
            ck_irq;
            wr(8'h10, 32'hC0, 4'hF);
            ck_irq;
            wr(8'h00, 32'h0, 4'hF);
            wr(8'h04, 32'h0, 4'hF);
            ck_irq;
        end
        chk(32'(entries), 32'(base + 10));
        $display("test gating done");
        // reset in mid-run with everything set
        wr(8'h00, 32'hFF, 4'hF);
        wr(8'h04, 32'hFF, 4'hF);
        ev(10'h3FF);
        @(posedge core_clk);
        reset_n <= 1'b0;
        @(posedge core_clk);
        reset_n <= 1'b1;
        en2 = 8'h00;
        en3 = 8'h00;
        fl2 = 8'h00;
        fl3 = 8'h00;
        gc = 8'h00;
        rd_all;
        ck_irq;
        $display("test mid-run reset done");
        // random enables, controls, events and clears
        repeat (8)
        begin
            rnd = lfsr(rnd);
            wr(8'h00, rnd, 4'hF);
            wr(8'h04, rnd >> 8, 4'hF);
            wr(8'h10, rnd >> 16, 4'hF);
            rnd = lfsr(rnd);
            ev(rnd[9:0]);
            ck_irq;
            rd(8'h08);
            rd(8'h0C);
            wr(8'h08, rnd >> 12, 4'hF);
            wr(8'h0C, rnd >> 20, 4'hF);
            ck_irq;
        end
        $display("test random done");
        stop_test;
    end
endmodule : tb
`default_nettype wire
